// *** common/dpll_pkg.sv ***
// constants, field widths and timing counts of the digital pll phase interpolator block
// assumes the single ref_clk domain; the reference input arrives asynchronously
// Function
// - detector compares divided reference and divided word clock, signed error out
// - second order loop drives the average detector error to zero at lock
// - filter sums gain-scaled proportional and integral paths into the tune value
// - sigma-delta and phase accumulator integrate tune into interpolator phase steps
// - feedback divider is 16 bits, divides word clock by setting plus two
// - reference divider is 16 bits, divides reference by setting plus two
// - direct offset is signed 22 bits, full scale 2097152
// - gains may change while running without loss of lock
// - reset held eight cycles clears all but the reset history; first error and step are zero
// - a 5-bit step word drives the interpolator step input
// - offset enable replaces the filter output with the direct offset
// - loop update divider is 16 bits, default 07ff, paces filter loads
package dpll_pkg;
  localparam int DIV_W = 16;
  localparam int GAIN_W = 5;
  localparam int ERR_W = 21;
  localparam int TUNE_W = 22;
  localparam int INT_W = 40;
  localparam int SD_W = 24;
  localparam int STEP_W = 5;
  localparam int INTERPOLATOR_STEP_SIZE_W = 4;
  localparam int RST_HOLD = 8;
  localparam logic [DIV_W-1:0] DIV_OFFSET = 16'h0002;
  localparam logic [DIV_W-1:0] UPDATE_DIV_DEFAULT = 16'h07ff;
  localparam logic [TUNE_W-1:0] TUNE_FULL_SCALE = 22'h200000;
  localparam logic [TUNE_W-1:0] TUNE_MAX = 22'h1fffff;
  localparam logic [TUNE_W-1:0] TUNE_MIN = 22'h200000;
  localparam logic [ERR_W-1:0] ERR_MAX = 21'h0fffff;
  localparam logic [ERR_W-1:0] ERR_MIN = 21'h100000;
endpackage

// *** hdl/dpll_div.sv ***
// programmable divider: one-cycle tick every (setting + 2) enabled inputs
// assumes setting is pseudo-static and all logic is on ref_clk
`timescale 1ns/1ps
`default_nettype none
module dpll_div (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control
  input wire logic step_en,
  input wire logic [15:0] setting,
  // result
  output logic tick
);
  logic [16:0] cnt_q;
  logic [16:0] term;

  // count to setting+1 so the period is setting+2
  assign term = {1'b0, setting} + 17'h00001;
  assign tick = step_en && (cnt_q >= term);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cnt_q <= 17'h00000;
    else if (tick)
      cnt_q <= 17'h00000;
    else if (step_en)
      cnt_q <= cnt_q + 17'h00001;
  end
endmodule // dpll_div
`default_nettype wire

// *** hdl/dpll_core.sv ***
// digital pll that steers a transmit phase interpolator from a reference signal
// assumes ref_clk is the transmit word clock; ref_in is asynchronous to it
`timescale 1ns/1ps
`default_nettype none
module dpll_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // reference signal
  input wire logic ref_in,
  // loop settings
  input wire logic [4:0] proportional_gain,
  input wire logic [4:0] integral_gain,
  input wire logic [15:0] ref_div_setting,
  input wire logic [15:0] fb_div_setting,
  input wire logic [15:0] update_div_setting,
  input wire logic [3:0] interpolator_step_size,
  input wire logic [21:0] offset_value,
  input wire logic offset_enable,
  input wire logic hold_tune,
  // interpolator
  output logic [4:0] phase_step_output,
  // status
  output logic [20:0] error_word,
  output logic [21:0] tune_word,
  output logic update_tick,
  output logic tune_saturated
);
  localparam int PW = dpll_pkg::INT_W;

  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic ref_edge, ref_tick, fb_tick;
  logic [20:0] phase_cnt_q;
  logic [20:0] error_q;
  logic [PW-1:0] integ_q;
  logic [PW-1:0] integ_sum, prop_term, int_term, filt_sum;
  logic [21:0] filt_sat, tune_q;
  logic [21:0] tune_mag;
  logic [dpll_pkg::SD_W-1:0] sd_acc_q;
  logic [dpll_pkg::SD_W:0] sd_sum;
  logic [4:0] step_q;
  logic ovf_q;

  // two-flop synchroniser, edge taken from the second and third stages
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end
    else
    begin
      ref_s1_q <= ref_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end
  assign ref_edge = ref_s2_q && !ref_s3_q;

  dpll_div u_ref_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .step_en(ref_edge),
    .setting(ref_div_setting),
    .tick(ref_tick)
  );

  dpll_div u_fb_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .step_en(1'b1),
    .setting(fb_div_setting),
    .tick(fb_tick)
  );

  dpll_div u_upd_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .step_en(1'b1),
    .setting(update_div_setting),
    .tick(update_tick)
  );

  // phase detector: signed up/down count, up on reference tick, down on feedback tick
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      phase_cnt_q <= '0;
    else if (update_tick)
      phase_cnt_q <= 21'(ref_tick) - 21'(fb_tick);
    else if (ref_tick && !fb_tick && phase_cnt_q != dpll_pkg::ERR_MAX)
      phase_cnt_q <= phase_cnt_q + 21'h000001;
    else if (fb_tick && !ref_tick && phase_cnt_q != dpll_pkg::ERR_MIN)
      phase_cnt_q <= phase_cnt_q - 21'h000001;
  end

  // error word latched once per loop update
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      error_q <= '0;
    else if (update_tick)
      error_q <= phase_cnt_q;
  end
  assign error_word = error_q;

  // gains act as right-shift amounts; changing them never disturbs the integrator
  assign prop_term = ($signed({{(PW-21){error_q[20]}}, error_q}) <<< 20) >>> proportional_gain;
  assign int_term = ($signed({{(PW-21){error_q[20]}}, error_q}) <<< 20) >>> integral_gain;

  function automatic logic [PW-1:0] sat_add(input logic [PW-1:0] a, input logic [PW-1:0] b);
    logic [PW-1:0] s;
    s = a + b;
    if (a[PW-1] == b[PW-1] && s[PW-1] != a[PW-1])
      s = a[PW-1] ? {1'b1, {(PW-1){1'b0}}} : {1'b0, {(PW-1){1'b1}}};
    return s;
  endfunction

  assign integ_sum = sat_add(integ_q, int_term);
  assign filt_sum = sat_add(integ_sum, prop_term);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      integ_q <= '0;
    else if (update_tick)
      integ_q <= integ_sum;
  end

  // scale down to tune width and clamp
  always_comb
  begin
    logic signed [PW-1:0] v;
    v = $signed(filt_sum) >>> 18;
    if (v > $signed({{(PW-22){1'b0}}, dpll_pkg::TUNE_MAX}))
      filt_sat = dpll_pkg::TUNE_MAX;
    else if (v < $signed({{(PW-22){1'b1}}, dpll_pkg::TUNE_MIN}))
      filt_sat = dpll_pkg::TUNE_MIN;
    else
      filt_sat = v[21:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tune_q <= '0;
      ovf_q <= 1'b0;
    end
    else if (offset_enable)
    begin
      tune_q <= offset_value;
      ovf_q <= (offset_value == dpll_pkg::TUNE_MAX) || (offset_value == dpll_pkg::TUNE_MIN);
    end
    else if (update_tick && !hold_tune)
    begin
      tune_q <= filt_sat;
      ovf_q <= (filt_sat == dpll_pkg::TUNE_MAX) || (filt_sat == dpll_pkg::TUNE_MIN);
    end
  end
  assign tune_word = tune_q;
  assign tune_saturated = ovf_q;

  // first-order sigma-delta on the tune magnitude: carries become phase steps
  // magnitude keeps zero tune at zero steps, so the step rate is linear through zero
  assign tune_mag = tune_q[21] ? 22'(-tune_q) : tune_q;
  assign sd_sum = {1'b0, sd_acc_q} + {1'b0, tune_mag, 2'b00};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sd_acc_q <= '0;
      step_q <= '0;
    end
    else
    begin
      sd_acc_q <= sd_sum[dpll_pkg::SD_W-1:0];
      // a carry steps in the direction of the tune sign
      if (sd_sum[dpll_pkg::SD_W] && !tune_q[21])
        step_q <= {1'b0, interpolator_step_size};
      else if (sd_sum[dpll_pkg::SD_W] && tune_q[21])
        step_q <= 5'(-{1'b0, interpolator_step_size});
      else
        step_q <= '0;
    end
  end
  assign phase_step_output = step_q;

  // srst history, so the hold check needs no known start value
  logic [dpll_pkg::RST_HOLD-1:0] rst_hist_q;
  always_ff @(posedge ref_clk)
  begin
    rst_hist_q <= {rst_hist_q[dpll_pkg::RST_HOLD-2:0], srst};
  end

  // cycles since the last tick, to check divider periods for any setting
  logic [16:0] fb_gap_q, upd_gap_q;
  always_ff @(posedge ref_clk)
  begin
    if (srst || fb_tick)
      fb_gap_q <= 17'h00000;
    else
      fb_gap_q <= fb_gap_q + 17'h00001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || update_tick)
      upd_gap_q <= 17'h00000;
    else
      upd_gap_q <= upd_gap_q + 17'h00001;
  end

  a_rst_zero_out: assert property (@(posedge ref_clk) $fell(srst) |-> (error_q == '0 && step_q == '0))
    else $error("outputs not zero after reset");
  a_err_on_tick: assert property (@(posedge ref_clk) disable iff (srst) !update_tick |=> $stable(error_q))
    else $error("error changed without update");
  a_offset_wins: assert property (@(posedge ref_clk) disable iff (srst) offset_enable |=> tune_q == $past(offset_value))
    else $error("offset not applied");
  a_hold_tune: assert property (@(posedge ref_clk) disable iff (srst) (hold_tune && !offset_enable) |=> $stable(tune_q))
    else $error("tune moved during hold");
  a_step_bound: assert property (@(posedge ref_clk) disable iff (srst) (step_q == '0) || (step_q == {1'b0, $past(interpolator_step_size)}) || (step_q == 5'(-{1'b0, $past(interpolator_step_size)})))
    else $error("bad step word");
  a_step_sign: assert property (@(posedge ref_clk) disable iff (srst) (!tune_q[21] && !$past(tune_q[21]) && !offset_enable) |-> !step_q[4] || step_q == '0)
    else $error("step against tune sign");
  a_upd_period: assert property (@(posedge ref_clk) disable iff (srst)
    (update_tick && $stable(update_div_setting)) |->
      upd_gap_q == {1'b0, update_div_setting} + 17'h00001)
    else $error("update period wrong");
  a_fb_period: assert property (@(posedge ref_clk) disable iff (srst)
    (fb_tick && $stable(fb_div_setting)) |->
      fb_gap_q == {1'b0, fb_div_setting} + 17'h00001)
    else $error("feedback period wrong");
  a_tune_clamp: assert property (@(posedge ref_clk) disable iff (srst) (!offset_enable && ovf_q) |-> (tune_q == dpll_pkg::TUNE_MAX || tune_q == dpll_pkg::TUNE_MIN))
    else $error("saturation flag without clamp");
  a_integ_hold: assert property (@(posedge ref_clk) disable iff (srst) !update_tick |=> $stable(integ_q))
    else $error("integrator moved off tick");
  a_rst_len: assert property (@(posedge ref_clk) $fell(srst) |-> &rst_hist_q)
    else $error("reset shorter than eight cycles");
endmodule // dpll_core
`default_nettype wire

// *** verification/dpll_ref_src.sv ***
// reference signal source standing in front of the dpll core
// assumes the bench picks the half period in ns; runs free, unrelated to ref_clk
`timescale 1ns/1ps
`default_nettype none
module dpll_ref_src (
  // setting
  input wire logic [15:0] half_ns,
  // reference signal
  output logic ref_in
);
  // rate set by the bench so divided rates match, or differ on purpose
  initial
  begin
    ref_in = 1'b0;
    #13;
    forever
    begin
      #(half_ns) ref_in = ~ref_in;
    end
  end
endmodule // dpll_ref_src
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for dpll_core
// assumes dpll_ref_src supplies the asynchronous reference input
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, srst, ref_in, offset_enable, hold_tune, update_tick, tune_saturated;
  logic [4:0] g_p, g_i, phase_step_output;
  logic [15:0] ref_div, fb_div, upd_div, half_ns;
  logic [3:0] step_size;
  logic [21:0] offset_value, tune_word;
  logic [20:0] error_word;
  logic [21:0] ofs [3] = '{22'h1fffff, 22'h200000, 22'h000123};
  logic sat_exp [3] = '{1'b1, 1'b1, 1'b0};
  int exp_pos [3] = '{32, 0, 0};
  int exp_neg [3] = '{0, 32, 0};
  logic [21:0] t_hold;
  int n_fail, check_count, gap, n_pos, n_neg;
  dpll_ref_src u_ref (.half_ns(half_ns), .ref_in(ref_in));
  dpll_core u_dut (.ref_clk(ref_clk), .srst(srst), .ref_in(ref_in),
    .proportional_gain(g_p), .integral_gain(g_i), .ref_div_setting(ref_div),
    .fb_div_setting(fb_div), .update_div_setting(upd_div),
    .interpolator_step_size(step_size), .offset_value(offset_value),
    .offset_enable(offset_enable), .hold_tune(hold_tune),
    .phase_step_output(phase_step_output), .error_word(error_word),
    .tune_word(tune_word), .update_tick(update_tick), .tune_saturated(tune_saturated));
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // bounded wait so a dead tick cannot hang the run
  initial
  begin
    #(6000 * 50);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
  initial
  begin
    // widest gains first, for fast acquisition
    srst = 1'b1; g_p = 5'h00; g_i = 5'h00; ref_div = 16'h0000; fb_div = 16'h000e;
    upd_div = 16'h003e; step_size = 4'h3; offset_value = '0; offset_enable = 1'b0;
    hold_tune = 1'b0; half_ns = 16'd100; n_fail = 0; check_count = 0;
    // eight edges: six would trip the eight-cycle reset length assertion
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2)
    begin
      cyc(1);
      chk(error_word === '0 && phase_step_output === '0 && tune_word === '0, "reset");
    end
    for (int i = 0; i < 200 && update_tick !== 1'b1; i++) cyc(1);
    gap = 1;
    cyc(1);
    while (update_tick !== 1'b1 && gap < 200)
    begin
      gap++;
      cyc(1);
    end
    chk(gap == 64, "update pacing");
    cyc(300);
    chk($signed(error_word) > 0, "error sign fast ref");
    chk(tune_word[21] === 1'b0 && tune_word !== '0, "tune direction");
    @(posedge ref_clk);
    hold_tune <= 1'b1;
    cyc(1);
    t_hold = tune_word;
    cyc(130);
    chk(tune_word === t_hold, "hold freezes tune");
    @(posedge ref_clk);
    hold_tune <= 1'b0;
    cyc(130);
    chk(tune_word !== t_hold && tune_word[21] === 1'b0, "tune resumes after hold");
    // narrower cleaning gains once acquired
    @(posedge ref_clk);
    g_p <= 5'h04;
    g_i <= 5'h0c;
    cyc(300);
    chk(tune_word[21] === 1'b0 && tune_word !== '0, "gain change");
    half_ns = 16'd400;
    cyc(300);
    chk($signed(error_word) < 0, "error sign slow ref");
    half_ns = 16'd200;
    cyc(300);
    chk($signed(error_word) <= 1 && $signed(error_word) >= -1, "matched");
    // full-scale offset is the widest pull used
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      offset_enable <= 1'b1;
      offset_value <= ofs[i];
      cyc(2);
      chk(tune_word === ofs[i], "offset override");
      chk(tune_saturated === sat_exp[i], "saturation flag");
      n_pos = 0;
      n_neg = 0;
      for (int j = 0; j < 64; j++)
      begin
        cyc(1);
        if (phase_step_output === 5'h03) n_pos++;
        else if (phase_step_output === 5'h1d) n_neg++;
        else chk(phase_step_output === 5'h00, "step value");
      end
      // step rate is tune / 2^22 of a step per cycle: half of 64 at full scale
      chk(n_pos >= exp_pos[i] - 1 && n_pos <= exp_pos[i] + 1, "advance count");
      chk(n_neg >= exp_neg[i] - 1 && n_neg <= exp_neg[i] + 1, "retard count");
    end
    @(posedge ref_clk);
    step_size <= 4'h0;
    cyc(2);
    for (int i = 0; i < 16; i++)
    begin
      cyc(1);
      chk(phase_step_output === 5'h00, "zero step size");
    end
    wrap_up();
  end
endmodule // tb
`default_nettype wire
